// file: pct_aux_channel.sv
`timescale 1ns/1ps
// auxiliary up-counter with one compare channel and shadow transfer
module pct_aux_channel (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      reset,
   // timer clock tick and run bit
   input  wire logic                      aux_tick,
   input  wire logic                      aux_run_bit,
   // shadow values from software
   input  wire logic [pct_pkg::AUX_W-1:0] aux_period_shadow,
   input  wire logic [pct_pkg::AUX_W-1:0] aux_compare_shadow,
   // software command pulses
   input  wire logic                      shadow_enable_set,
   input  wire logic                      shadow_enable_clear,
   input  wire logic                      state_force_high,
   input  wire logic                      state_force_low,
   // timer status
   output logic      [pct_pkg::AUX_W-1:0] aux_count,
   output logic      [pct_pkg::AUX_W-1:0] aux_compare_value,
   output logic                           aux_compare_event,
   output logic                           aux_period_match,
   output logic                           aux_zero_match,
   output logic                           aux_shadow_strobe,
   output logic                           aux_shadow_enable,
   output logic                           aux_compare_state
);
   logic [pct_pkg::AUX_W-1:0] period_r;   // active period value

   // comparators
   assign aux_compare_event = (aux_count == aux_compare_value);
   assign aux_period_match  = (aux_count == period_r);
   assign aux_zero_match    = (aux_count == pct_pkg::AUX_RST);
   // transfer allowed when stopped or on an enabled period match
   assign aux_shadow_strobe = !aux_run_bit
                              || (aux_shadow_enable && aux_period_match);

   // counter: clears after period match, counts up only
   always_ff @(posedge clock)
   begin
      if (reset)
         aux_count <= pct_pkg::AUX_RST;
      else if (aux_tick && aux_run_bit)
      begin
         if (aux_period_match)
            aux_count <= pct_pkg::AUX_RST;
         else
            aux_count <= aux_count + 16'h0001;
      end
   end

   // shadow transfer on the next timer clock while the strobe is active
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         period_r          <= pct_pkg::AUX_RST;
         aux_compare_value <= pct_pkg::AUX_RST;
      end
      else if (aux_tick && aux_shadow_strobe)
      begin
         period_r          <= aux_period_shadow;
         aux_compare_value <= aux_compare_shadow;
      end
   end

   // shadow enable: write-one set and clear, self clearing at transfer
   always_ff @(posedge clock)
   begin
      if (reset)
         aux_shadow_enable <= pct_pkg::BIT_RST;
      else if (shadow_enable_set)
         aux_shadow_enable <= 1'b1;
      else if (shadow_enable_clear || (aux_tick && aux_shadow_strobe))
         aux_shadow_enable <= 1'b0;
   end

   // compare state bit; software force takes precedence
   always_ff @(posedge clock)
   begin
      if (reset)
         aux_compare_state <= pct_pkg::BIT_RST;
      else if (state_force_high)
         aux_compare_state <= 1'b1;
      else if (state_force_low)
         aux_compare_state <= 1'b0;
      else if (aux_tick && aux_run_bit)
      begin
         if (aux_compare_event)
            aux_compare_state <= 1'b1;
         else if (aux_zero_match)
            aux_compare_state <= 1'b0;
      end
   end
endmodule

// file: pct_chk.sv
`timescale 1ns/1ps
// sees only top ports; one clock domain, so clocking and disable are shared
module pct_chk (
   input wire logic clock, reset, aux_tick, aux_run_bit, state_force_high, state_force_low,
   input wire logic [pct_pkg::AUX_W-1:0] aux_compare_shadow, aux_count, aux_compare_value,
   input wire logic aux_compare_event, aux_period_match, aux_zero_match, aux_shadow_strobe,
   input wire logic aux_shadow_enable, aux_compare_state, gate_pattern_transfer,
   input wire pct_pkg::pct_trap_cfg_t trap_cfg,
   input wire logic trap_state, pattern_transfer_flag,
   input wire logic [pct_pkg::TRAP_OUT_N-1:0] trap_passive,
   input wire pct_pkg::pct_mcm_cfg_t mcm_cfg,
   input wire logic [pct_pkg::CH_N-1:0] channel_compare_out, channel_gate_shadow,
   input wire logic [pct_pkg::CH_N-1:0] channel_gate_pattern, channel_gated_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   property p_cmp; aux_compare_event == (aux_count == aux_compare_value); endproperty
   a_cmp: assert property (p_cmp) else $error("compare match wrong");
   property p_stb; aux_shadow_strobe == (!aux_run_bit | aux_shadow_enable & aux_period_match);
   endproperty
   a_stb: assert property (p_stb) else $error("shadow strobe wrong");
   property p_ld; aux_tick && aux_shadow_strobe |=> aux_compare_value == $past(aux_compare_shadow);
   endproperty
   a_ld: assert property (p_ld) else $error("compare not loaded");
   property p_hold; !aux_run_bit && !state_force_high && !state_force_low
      |=> $stable(aux_compare_state); endproperty
   a_hold: assert property (p_hold) else $error("state moved while stopped");
   property p_set; aux_tick && aux_run_bit && aux_compare_event && !state_force_low
      |=> aux_compare_state; endproperty
   a_set: assert property (p_set) else $error("state not set");
   property p_clr; aux_tick && aux_run_bit && aux_zero_match && !aux_compare_event
      && !state_force_high |=> !aux_compare_state; endproperty
   a_clr: assert property (p_clr) else $error("state not cleared");
   property p_pas; 1 |=> trap_passive == $past(trap_cfg.out_enable & {7{trap_state}}); endproperty
   a_pas: assert property (p_pas) else $error("passive outputs wrong");
   property p_gate; mcm_cfg.multichannel_enable
      |=> channel_gated_out == $past(channel_compare_out & channel_gate_pattern); endproperty
   a_gate: assert property (p_gate) else $error("gated outputs wrong");
   property p_ptf; gate_pattern_transfer
      |=> pattern_transfer_flag && channel_gate_pattern == $past(channel_gate_shadow); endproperty
   a_ptf: assert property (p_ptf) else $error("pattern transfer wrong");
endmodule
bind pct_top pct_chk chk (.*);

// file: pct_pkg.sv
package pct_pkg;
   // counter and compare width of the auxiliary timer
   localparam int AUX_W = 16;
   // number of gated compare channels
   localparam int CH_N = 6;
   // number of trap-gated outputs: six main-timer, one second-timer
   localparam int TRAP_OUT_N = 7;
   // hall input width
   localparam int HALL_W = 3;

   // values after reset
   localparam logic [AUX_W-1:0] AUX_RST = 16'h0000;
   localparam logic [CH_N-1:0]  PAT_RST = 6'h00;
   localparam logic             BIT_RST = 1'b0;

   // switching event select codes
   localparam logic [2:0] SW_NONE   = 3'h0;
   localparam logic [2:0] SW_HALL   = 3'h1;
   localparam logic [2:0] SW_T2_PM  = 3'h2;
   localparam logic [2:0] SW_T1_OMD = 3'h3;
   localparam logic [2:0] SW_CH1_UP = 3'h4;
   localparam logic [2:0] SW_T1_PMU = 3'h5;

   // switching synchronisation select codes
   localparam logic [1:0] SYN_DIRECT = 2'h0;
   localparam logic [1:0] SYN_T2_ZM  = 2'h1;
   localparam logic [1:0] SYN_T1_ZM  = 2'h2;

   // trap state exit modes
   typedef enum logic [1:0] {
      EXIT_MAIN   = 2'b00,
      EXIT_SECOND = 2'b01,
      EXIT_NOW    = 2'b10,
      EXIT_NOW2   = 2'b11
   } pct_exit_t;

   // trap configuration group
   typedef struct packed {
      logic                  input_enable;
      logic                  flag_clear_mode;
      pct_exit_t             exit_mode;
      logic [TRAP_OUT_N-1:0] out_enable;
   } pct_trap_cfg_t;

   // multi-channel configuration group
   typedef struct packed {
      logic       multichannel_enable;
      logic [2:0] switch_event_select;
      logic [1:0] switch_sync_select;
      logic       main_strobe_enable;
      logic       second_strobe_enable;
   } pct_mcm_cfg_t;

   // events from the main and second timers
   typedef struct packed {
      logic main_timer_period_match;
      logic main_timer_zero_match;
      logic main_timer_one_match;
      logic channel_one_compare_event;
      logic count_direction;
      logic second_timer_period_match;
      logic second_timer_zero_match;
   } pct_tmr_evt_t;
endpackage

// file: pct_power.sv
`timescale 1ns/1ps
// power stage: fault line with pull-up, released reads high; one drive level for six phases
module pct_power (
   input wire logic clock, trip, pwm_on,
   output logic trap_input_n,
   output logic [pct_pkg::CH_N-1:0] pwm
);
   // fault pulled low only while tripped
   always_ff @(posedge clock) trap_input_n <= !trip;
   always_ff @(posedge clock) pwm <= {pct_pkg::CH_N{pwm_on}};
endmodule

// file: pct_sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module pct_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         reset,
   // reset level and raw pin
   input  wire logic [W-1:0] rst_val,
   input  wire logic [W-1:0] pin,
   // synchronised level
   output logic      [W-1:0] sync
);
   logic [W-1:0] meta_r;   // first stage, read only by second stage

   // reset value is a port, so reset is synchronous and takes effect on a clock edge
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         meta_r <= rst_val;
         sync   <= rst_val;
      end
      else
      begin
         meta_r <= pin;
         sync   <= meta_r;
      end
   end
endmodule

// file: pct_top.sv
`timescale 1ns/1ps
module pct_top (
   // clock and reset
   input  wire logic                           clock,
   input  wire logic                           reset,
   // auxiliary timer control
   input  wire logic                           aux_tick,
   input  wire logic                           aux_run_bit,
   input  wire logic [pct_pkg::AUX_W-1:0]      aux_period_shadow,
   input  wire logic [pct_pkg::AUX_W-1:0]      aux_compare_shadow,
   input  wire logic                           shadow_enable_set,
   input  wire logic                           shadow_enable_clear,
   input  wire logic                           state_force_high,
   input  wire logic                           state_force_low,
   // auxiliary timer status
   output logic      [pct_pkg::AUX_W-1:0]      aux_count,
   output logic      [pct_pkg::AUX_W-1:0]      aux_compare_value,
   output logic                                aux_compare_event,
   output logic                                aux_period_match,
   output logic                                aux_zero_match,
   output logic                                aux_shadow_strobe,
   output logic                                aux_shadow_enable,
   output logic                                aux_compare_state,
   // trap pin and configuration
   input  wire logic                           trap_input_n,
   input  wire pct_pkg::pct_trap_cfg_t         trap_cfg,
   // software trap status commands
   input  wire logic                           trap_flag_set,
   input  wire logic                           trap_flag_clear,
   input  wire logic                           trap_state_set,
   input  wire logic                           trap_state_clear,
   // trap status and output passivation
   output logic                                trap_flag,
   output logic                                trap_state,
   output logic      [pct_pkg::TRAP_OUT_N-1:0] trap_passive,
   // events of the main and second timers
   input  wire pct_pkg::pct_tmr_evt_t          tmr_evt,
   // hall pins and expected pattern
   input  wire logic [pct_pkg::HALL_W-1:0]     hall_inputs,
   input  wire logic                           hall_sample,
   input  wire logic [pct_pkg::HALL_W-1:0]     hall_expected,
   output logic                                correct_hall_event,
   // multi-channel configuration and shadow write
   input  wire pct_pkg::pct_mcm_cfg_t          mcm_cfg,
   input  wire logic                           pattern_write,
   input  wire logic [pct_pkg::CH_N-1:0]       channel_gate_shadow_in,
   input  wire logic                           gate_transfer_request,
   input  wire logic                           pattern_flag_clear,
   // compare channel outputs before gating
   input  wire logic [pct_pkg::CH_N-1:0]       channel_compare_out,
   // multi-channel status and gated outputs
   output logic      [pct_pkg::CH_N-1:0]       channel_gate_shadow,
   output logic      [pct_pkg::CH_N-1:0]       channel_gate_pattern,
   output logic      [pct_pkg::CH_N-1:0]       channel_gated_out,
   output logic                                reminder_flag,
   output logic                                pattern_transfer_flag,
   output logic                                gate_pattern_transfer,
   output logic                                main_timer_shadow_strobe,
   output logic                                second_timer_shadow_strobe
);
   // synchronised pin levels and internal trap and pattern control signals
   logic                         trap_n_sync;   // trap input after two flops
   logic [pct_pkg::HALL_W-1:0]   hall_sync;     // hall inputs after two flops
   logic                         trap_event;    // enabled trap condition
   logic                         trap_exit_ok;  // exit condition for the trap state
   logic                         switch_event;  // selected switching event
   logic                         sync_event;    // selected synchronisation event
   logic                         hw_transfer;   // hardware-initiated transfer
   logic                         sw_pending_r;  // software request waiting
   logic                         sw_pending_nxt;
   logic                         sw_request;    // software request this cycle

   // auxiliary timer with its compare channel
   pct_aux_channel u_aux (
      .clock               (clock),
      .reset               (reset),
      .aux_tick            (aux_tick),
      .aux_run_bit         (aux_run_bit),
      .aux_period_shadow   (aux_period_shadow),
      .aux_compare_shadow  (aux_compare_shadow),
      .shadow_enable_set   (shadow_enable_set),
      .shadow_enable_clear (shadow_enable_clear),
      .state_force_high    (state_force_high),
      .state_force_low     (state_force_low),
      .aux_count           (aux_count),
      .aux_compare_value   (aux_compare_value),
      .aux_compare_event   (aux_compare_event),
      .aux_period_match    (aux_period_match),
      .aux_zero_match      (aux_zero_match),
      .aux_shadow_strobe   (aux_shadow_strobe),
      .aux_shadow_enable   (aux_shadow_enable),
      .aux_compare_state   (aux_compare_state)
   );

   // trap input idles high, so it resets to the inactive level
   pct_sync2 #(
      .W (1)
   ) u_trap_sync (
      .clock   (clock),
      .reset   (reset),
      .rst_val (1'b1),
      .pin     (trap_input_n),
      .sync    (trap_n_sync)
   );

   // hall pins cross into the module clock before comparison
   pct_sync2 #(
      .W (pct_pkg::HALL_W)
   ) u_hall_sync (
      .clock   (clock),
      .reset   (reset),
      .rst_val (3'h0),
      .pin     (hall_inputs),
      .sync    (hall_sync)
   );

   // ------------------------------------------------------------------
   // hall compare
   // ------------------------------------------------------------------

   // a sampled match with the expected pattern means the rotor advanced;
   // registered so the event is a clean one-cycle pulse
   always_ff @(posedge clock)
   begin
      if (reset)
         correct_hall_event <= pct_pkg::BIT_RST;
      else
         correct_hall_event <= hall_sample && (hall_sync == hall_expected);
   end

   // ------------------------------------------------------------------
   // trap logic
   // ------------------------------------------------------------------

   // trap condition only counts when the input is enabled
   assign trap_event = !trap_n_sync && trap_cfg.input_enable;

   // exit condition per mode; the synchronised modes wait for a period start
   always_comb
   begin
      trap_exit_ok = 1'b0;
      case (trap_cfg.exit_mode)
         pct_pkg::EXIT_MAIN:
            trap_exit_ok = !trap_flag && tmr_evt.main_timer_zero_match;
         pct_pkg::EXIT_SECOND:
            trap_exit_ok = !trap_flag && tmr_evt.second_timer_zero_match;
         pct_pkg::EXIT_NOW,
         pct_pkg::EXIT_NOW2:
            trap_exit_ok = !trap_flag;
         default:
            trap_exit_ok = 1'b0;
      endcase
   end

   // trap flag: set wins over any clear so a trap is never lost
   always_ff @(posedge clock)
   begin
      if (reset)
         trap_flag <= pct_pkg::BIT_RST;
      else if (trap_event || trap_flag_set)
         trap_flag <= 1'b1;
      else if (trap_flag_clear)
         trap_flag <= 1'b0;
      else if (!trap_cfg.flag_clear_mode && trap_n_sync)
         trap_flag <= 1'b0;
   end

   // trap state: entered on a trap event or by software set, left per exit mode or by software
   always_ff @(posedge clock)
   begin
      if (reset)
         trap_state <= pct_pkg::BIT_RST;
      else if (trap_event || trap_state_set)
         trap_state <= 1'b1;
      else if (trap_state_clear)
         trap_state <= 1'b0;
      else if (trap_exit_ok)
         trap_state <= 1'b0;
   end

   // passivation is registered so the gate driver sees no glitches
   always_ff @(posedge clock)
   begin
      if (reset)
         trap_passive <= 7'h00;
      else
         trap_passive <= trap_cfg.out_enable & {pct_pkg::TRAP_OUT_N{trap_state}};
   end

   // ------------------------------------------------------------------
   // multi-channel pattern
   // ------------------------------------------------------------------

   // switching event selection; reserved codes never trigger
   always_comb
   begin
      switch_event = 1'b0;
      case (mcm_cfg.switch_event_select)
         pct_pkg::SW_NONE:
            switch_event = 1'b0;
         pct_pkg::SW_HALL:
            switch_event = correct_hall_event;
         pct_pkg::SW_T2_PM:
            switch_event = tmr_evt.second_timer_period_match;
         pct_pkg::SW_T1_OMD:
            switch_event = tmr_evt.main_timer_one_match && tmr_evt.count_direction;
         pct_pkg::SW_CH1_UP:
            switch_event = tmr_evt.channel_one_compare_event
                           && !tmr_evt.count_direction;
         pct_pkg::SW_T1_PMU:
            switch_event = tmr_evt.main_timer_period_match
                           && !tmr_evt.count_direction;
         default:
            switch_event = 1'b0;
      endcase
   end

   // synchronisation selection; the direct mode passes at once
   always_comb
   begin
      sync_event = 1'b0;
      case (mcm_cfg.switch_sync_select)
         pct_pkg::SYN_DIRECT:
            sync_event = 1'b1;
         pct_pkg::SYN_T2_ZM:
            sync_event = tmr_evt.second_timer_zero_match;
         pct_pkg::SYN_T1_ZM:
            sync_event = tmr_evt.main_timer_zero_match;
         default:
            sync_event = 1'b0;
      endcase
   end

   // hardware transfer: pending reminder or fresh event meets the sync point;
   // in direct mode a fresh event transfers in its own cycle
   assign hw_transfer = mcm_cfg.multichannel_enable && sync_event
                        && (reminder_flag || switch_event);

   // a software request rides the same sync path as a hardware event
   assign sw_request = sw_pending_r && sync_event;

   // the transfer pulse, also used by the timer strobes
   assign gate_pattern_transfer = hw_transfer || sw_request;

   // software request is remembered until its sync point arrives
   always_comb
   begin
      sw_pending_nxt = sw_pending_r;
      if (pattern_write && gate_transfer_request)
         sw_pending_nxt = 1'b1;
      else if (sw_request)
         sw_pending_nxt = 1'b0;
   end

   // pending software request register
   always_ff @(posedge clock)
   begin
      if (reset)
         sw_pending_r <= pct_pkg::BIT_RST;
      else
         sw_pending_r <= sw_pending_nxt;
   end

   // reminder flag: event sets it, transfer or disable clears it;
   // a new event in the transfer cycle wins, unless it was consumed directly
   always_ff @(posedge clock)
   begin
      if (reset)
         reminder_flag <= pct_pkg::BIT_RST;
      else if (!mcm_cfg.multichannel_enable)
         reminder_flag <= 1'b0;
      else if (switch_event && !(sync_event && !reminder_flag))
         reminder_flag <= 1'b1;
      else if (gate_pattern_transfer)
         reminder_flag <= 1'b0;
   end

   // shadow pattern written by software
   always_ff @(posedge clock)
   begin
      if (reset)
         channel_gate_shadow <= pct_pkg::PAT_RST;
      else if (pattern_write)
         channel_gate_shadow <= channel_gate_shadow_in;
   end

   // active pattern; a write in the transfer cycle loads next time,
   // because the old shadow content is what gets copied
   always_ff @(posedge clock)
   begin
      if (reset)
         channel_gate_pattern <= pct_pkg::PAT_RST;
      else if (gate_pattern_transfer)
         channel_gate_pattern <= channel_gate_shadow;
   end

   // sticky transfer flag; a transfer wins over a software clear
   always_ff @(posedge clock)
   begin
      if (reset)
         pattern_transfer_flag <= pct_pkg::BIT_RST;
      else if (gate_pattern_transfer)
         pattern_transfer_flag <= 1'b1;
      else if (pattern_flag_clear)
         pattern_transfer_flag <= 1'b0;
   end

   // timer shadow strobes accompany the pattern transfer when enabled
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         main_timer_shadow_strobe   <= pct_pkg::BIT_RST;
         second_timer_shadow_strobe <= pct_pkg::BIT_RST;
      end
      else
      begin
         main_timer_shadow_strobe   <= gate_pattern_transfer
                                       && mcm_cfg.main_strobe_enable;
         second_timer_shadow_strobe <= gate_pattern_transfer
                                       && mcm_cfg.second_strobe_enable;
      end
   end

   // per-channel gating; disabled mode passes every channel through
   genvar gi;
   generate
      for (gi = 0; gi < pct_pkg::CH_N; gi++)
      begin : g_gate
         always_ff @(posedge clock)
         begin
            if (reset)
               channel_gated_out[gi] <= 1'b0;
            else if (mcm_cfg.multichannel_enable)
               channel_gated_out[gi] <= channel_compare_out[gi]
                                        && channel_gate_pattern[gi];
            else
               channel_gated_out[gi] <= channel_compare_out[gi];
         end
      end
   endgenerate
endmodule

// file: pct_top_tb_top.sv
`timescale 1ns/1ps
// directed bench; inputs change on the falling edge
module pct_top_tb_top;
   logic clock = 0, reset = 1, aux_tick = 0, aux_run_bit = 0, trip = 0, pwm_on = 0;
   logic shadow_enable_set = 0, shadow_enable_clear = 0, state_force_high = 0;
   logic state_force_low = 0, trap_flag_set = 0, trap_flag_clear = 0, trap_state_set = 0;
   logic trap_state_clear = 0, hall_sample = 0, pattern_write = 0, gate_transfer_request = 0;
   logic pattern_flag_clear = 0, trap_input_n, aux_compare_event, aux_period_match;
   logic aux_zero_match, aux_shadow_strobe, aux_shadow_enable, aux_compare_state;
   logic trap_flag, trap_state, correct_hall_event, reminder_flag, pattern_transfer_flag;
   logic gate_pattern_transfer, main_timer_shadow_strobe, second_timer_shadow_strobe;
   logic [2:0] hall_inputs = 3'h0, hall_expected = 3'h0;
   logic [15:0] aux_period_shadow = 16'h0003, aux_compare_shadow = 16'h0002;
   logic [15:0] aux_count, aux_compare_value;
   logic [5:0] channel_gate_shadow_in = 6'h00, channel_compare_out, channel_gate_shadow;
   logic [5:0] channel_gate_pattern, channel_gated_out;
   logic [6:0] trap_passive;
   pct_pkg::pct_trap_cfg_t trap_cfg = '0;
   pct_pkg::pct_mcm_cfg_t mcm_cfg = '0;
   pct_pkg::pct_tmr_evt_t tmr_evt = '0;
   int err_count = 0, comparisons = 0;
   always #12.5 clock = ~clock;
   pct_top dut (.*);
   pct_power partner (.clock(clock), .trip(trip), .pwm_on(pwm_on),
      .trap_input_n(trap_input_n), .pwm(channel_compare_out));
   task cyc(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      cyc(1);
      s = 0;
   endtask
   task chk(input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog: the tests need about 80 cycles
   initial
   begin
      #100us;
      err_count++;
      finish_test;
   end
   initial
   begin
      cyc(20);
      reset = 0;
      aux_tick = 1;
      cyc(1);
      chk(aux_compare_value, 16'h0002);
      aux_run_bit = 1;
      cyc(3);
      chk(aux_compare_state, 1'b1);
      cyc(2);
      chk(aux_count, 16'h0001);
      chk(aux_compare_state, 1'b0);
      aux_tick = 0;
      aux_compare_shadow = 16'h0001;
      pulse(shadow_enable_set);
      pulse(shadow_enable_clear);
      chk(aux_shadow_enable, 1'b0);
      pulse(shadow_enable_set);
      chk(aux_shadow_enable, 1'b1);
      aux_tick = 1;
      cyc(3);
      chk(aux_compare_value, 16'h0001);
      chk(aux_shadow_enable, 1'b0);
      aux_tick = 0;
      pulse(state_force_low);
      chk(aux_compare_state, 1'b0);
      pulse(state_force_high);
      aux_run_bit = 0;
      aux_tick = 1;
      cyc(3);
      chk(aux_compare_state, 1'b1);
      $display("aux timer test done");
      trap_cfg = '{1'b1, 1'b1, pct_pkg::EXIT_MAIN, 7'h41};
      trip = 1;
      cyc(6);
      chk(trap_passive, 7'h41);
      trip = 0;
      cyc(8);
      chk(trap_flag, 1'b1);
      pulse(trap_flag_clear);
      chk(trap_flag, 1'b0);
      chk(trap_state, 1'b1);
      tmr_evt.main_timer_zero_match = 1;
      cyc(1);
      tmr_evt.main_timer_zero_match = 0;
      chk(trap_state, 1'b0);
      trap_cfg = '{1'b0, 1'b0, pct_pkg::EXIT_NOW, 7'h41};
      trip = 1;
      cyc(6);
      chk(trap_state, 1'b0);
      trap_cfg.input_enable = 1;
      cyc(1);
      chk(trap_flag, 1'b1);
      trip = 0;
      cyc(5);
      chk(trap_flag, 1'b0);
      chk(trap_state, 1'b0);
      pulse(trap_state_set);
      chk(trap_state, 1'b1);
      pulse(trap_flag_set);
      chk(trap_flag, 1'b1);
      $display("trap test done");
      pwm_on = 1;
      mcm_cfg = '{1'b1, pct_pkg::SW_T2_PM, pct_pkg::SYN_T1_ZM, 1'b1, 1'b1};
      channel_gate_shadow_in = 6'h2D;
      pulse(pattern_write);
      tmr_evt.second_timer_period_match = 1;
      cyc(1);
      tmr_evt.second_timer_period_match = 0;
      chk(reminder_flag, 1'b1);
      tmr_evt.main_timer_zero_match = 1;
      cyc(1);
      tmr_evt.main_timer_zero_match = 0;
      chk(channel_gate_pattern, 6'h2D);
      chk(main_timer_shadow_strobe, 1'b1);
      chk(reminder_flag, 1'b0);
      cyc(1);
      chk(channel_gated_out, 6'h2D);
      chk(pattern_transfer_flag, 1'b1);
      pulse(pattern_flag_clear);
      chk(pattern_transfer_flag, 1'b0);
      hall_inputs = 3'h5;
      hall_expected = 3'h5;
      mcm_cfg = '{1'b1, pct_pkg::SW_HALL, pct_pkg::SYN_DIRECT, 1'b0, 1'b1};
      channel_gate_shadow_in = 6'h12;
      pulse(pattern_write);
      cyc(1);
      pulse(hall_sample);
      chk(correct_hall_event, 1'b1);
      chk(gate_pattern_transfer, 1'b1);
      cyc(1);
      chk(channel_gate_pattern, 6'h12);
      chk(main_timer_shadow_strobe, 1'b0);
      chk(second_timer_shadow_strobe, 1'b1);
      mcm_cfg.switch_event_select = pct_pkg::SW_NONE;
      channel_gate_shadow_in = 6'h33;
      gate_transfer_request = 1;
      pulse(pattern_write);
      gate_transfer_request = 0;
      chk(gate_pattern_transfer, 1'b1);
      cyc(1);
      chk(channel_gate_pattern, 6'h33);
      mcm_cfg = '{1'b1, pct_pkg::SW_T2_PM, pct_pkg::SYN_T2_ZM, 1'b0, 1'b0};
      tmr_evt.second_timer_period_match = 1;
      cyc(1);
      tmr_evt.second_timer_period_match = 0;
      chk(reminder_flag, 1'b1);
      mcm_cfg.multichannel_enable = 0;
      cyc(1);
      chk(reminder_flag, 1'b0);
      chk(channel_gated_out, 6'h3F);
      $display("multichannel test done");
      finish_test;
   end
endmodule
